// >>> rmblc_params.svh
// Purpose: Offsets, field positions, reset values and timing counts
// Assumes: Included by the serial port and control design files of the reset/mode block
// Notes:   Definitions only
`ifndef RMBLC_PARAMS_SVH
`define RMBLC_PARAMS_SVH

// ----------------------------------------------------------------------
// Register offsets (7-bit serial address)
// ----------------------------------------------------------------------
`define RMBLC_OFS_SOFT_RESET   7'h00
`define RMBLC_OFS_ADC_LOW_PWR  7'h07
`define RMBLC_OFS_TEST_LOOP    7'h0d
`define RMBLC_OFS_RX_BIAS      7'h13

// ----------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------
`define RMBLC_BIT_SOFT_RESET   5
`define RMBLC_BIT_ADC_LOW_PWR  4
`define RMBLC_BIT_ANA_LOOP     7
`define RMBLC_BIT_DIG_LOOP     6
`define RMBLC_BIT_RX_TRISTATE  5
`define RMBLC_ADC_LP_BIAS      3'h3

// ----------------------------------------------------------------------
// Reset values; low-power defaults per strap pair {duplex, default_select}
// ----------------------------------------------------------------------
`define RMBLC_DEF_ADC_LP_00    8'h00
`define RMBLC_DEF_ADC_LP_01    8'h00
`define RMBLC_DEF_ADC_LP_10    8'h00
`define RMBLC_DEF_ADC_LP_11    8'h00
`define RMBLC_DEF_TEST_LOOP    8'h00
`define RMBLC_DEF_RX_BIAS      8'h00

// ----------------------------------------------------------------------
// Timing
// ----------------------------------------------------------------------
`define RMBLC_CLK_PERIOD_NS    10
`define RMBLC_RESET_MIN_NS     50
`define RMBLC_RESET_MIN_CYC    \
	((`RMBLC_RESET_MIN_NS + `RMBLC_CLK_PERIOD_NS - 1) / `RMBLC_CLK_PERIOD_NS)

`endif

// >>> rmblc_pkg.sv
// Purpose: Shared types of the reset/mode block
// Assumes: Nothing
// Notes:   Constants live in rmblc_params.svh
package rmblc_pkg;
	typedef logic [7:0] rmblc_byte_t;
	typedef logic [6:0] rmblc_addr_t;
	typedef enum logic [1:0] {
		RMBLC_SP_IDLE,
		RMBLC_SP_HEAD,
		RMBLC_SP_DATA,
		RMBLC_SP_DONE
	} rmblc_sp_state_t;
endpackage : rmblc_pkg

// >>> rmblc_sync.sv
// Purpose: Three-stage input synchroniser with agreement filter
// Assumes: Input is asynchronous to SYS_CLK
// Notes:   Output moves only when stages two and three agree
`timescale 1ns/100ps
`default_nettype none
module rmblc_sync #(
	parameter int W = 1,
	parameter logic [W-1:0] INIT = '0
) (
	input  wire logic         clk_i,   // System clock
	input  wire logic         rst_i,   // Async reset, high
	input  wire logic [W-1:0] d_i,     // Raw pin level
	output logic      [W-1:0] q_o      // Filtered level
);
	logic [W-1:0] s1;
	logic [W-1:0] s2;
	logic [W-1:0] s3;

	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			s1 <= INIT;
			s2 <= INIT;
			s3 <= INIT;
		end else begin
			s1 <= d_i;
			s2 <= s1;
			s3 <= s2;
		end
	end

	// Per bit, a change counts only once two stages agree
	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			q_o <= INIT;
		end else begin
			q_o <= (s2 & s3) | (q_o & (s2 ^ s3));
		end
	end
endmodule : rmblc_sync
`default_nettype wire

// >>> rmblc_serial.sv
// Purpose: Serial configuration port slave, sampled on SYS_CLK
// Assumes: Filtered select, clock and data levels; 16-bit frames
// Notes:   Frame is R/W, 7 address bits, 8 data bits, MSB first
`timescale 1ns/100ps
`default_nettype none
`include "rmblc_params.svh"
module rmblc_serial (
	input  wire logic                 clk_i,     // System clock
	input  wire logic                 rst_i,     // Async reset, high
	input  wire logic                 sel_n_i,   // Port select, low
	input  wire logic                 sclk_i,    // Serial clock level
	input  wire logic                 sdi_i,     // Serial data in
	input  wire rmblc_pkg::rmblc_byte_t rdata_i, // Read data for addr_o
	output rmblc_pkg::rmblc_addr_t    addr_o,    // Frame address
	output rmblc_pkg::rmblc_byte_t    wdata_o,   // Write data
	output logic                      wr_o,      // Write strobe, pulse
	output logic                      sdo_o,     // Serial data out
	output logic                      sdo_oe_o   // Drive enable
);
	import rmblc_pkg::*;

	rmblc_sp_state_t state;
	logic            sclk_q;
	logic            rd;
	logic            loaded;
	logic [2:0]      cnt;
	rmblc_byte_t     sr;
	logic            rise;
	logic            fall;

	assign rise = sclk_i & ~sclk_q;
	assign fall = ~sclk_i & sclk_q;

	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			sclk_q <= 1'b0;
		end else begin
			sclk_q <= sclk_i;
		end
	end

	// A high select always ends the frame: the port stays idle
	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			state  <= RMBLC_SP_IDLE;
			cnt    <= 3'h0;
			sr     <= 8'h00;
			rd     <= 1'b0;
			addr_o <= 7'h00;
			wr_o   <= 1'b0;
			wdata_o <= 8'h00;
		end else begin
			wr_o <= 1'b0;
			if (sel_n_i) begin
				state <= RMBLC_SP_IDLE;
			end else begin
				case (state)
				RMBLC_SP_IDLE: begin
					cnt   <= 3'h0;
					state <= RMBLC_SP_HEAD;
				end
				RMBLC_SP_HEAD: begin
					if (rise) begin
						sr  <= {sr[6:0], sdi_i};
						cnt <= cnt + 3'h1;
						if (cnt == 3'h7) begin
							rd     <= sr[6];
							addr_o <= {sr[5:0], sdi_i};
							state  <= RMBLC_SP_DATA;
						end
					end
				end
				RMBLC_SP_DATA: begin
					if (rise) begin
						sr  <= {sr[6:0], sdi_i};
						cnt <= cnt + 3'h1;
						if (cnt == 3'h7) begin
							wr_o    <= ~rd;
							wdata_o <= {sr[6:0], sdi_i};
							state   <= RMBLC_SP_DONE;
						end
					end
				end
				default: begin
					state <= RMBLC_SP_DONE;
				end
				endcase
			end
		end
	end

	// Read data leaves on falling edges; the first fall loads the byte
	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			sdo_o    <= 1'b0;
			sdo_oe_o <= 1'b0;
			loaded   <= 1'b0;
		end else if (sel_n_i || state != RMBLC_SP_DATA || !rd) begin
			sdo_oe_o <= 1'b0;
			loaded   <= 1'b0;
		end else if (fall) begin
			sdo_oe_o <= 1'b1;
			loaded   <= 1'b1;
			if (!loaded) begin
				sdo_o <= rdata_i[7];
			end else begin
				sdo_o <= rdata_i[3'h7 - cnt];
			end
		end
	end
endmodule : rmblc_serial
`default_nettype wire

// >>> rmblc_ctrl.sv
// Purpose: Strap defaults, resets, bias fields and loopback controls
// Assumes: All pins asynchronous; RX_WORD_I, TX_WORD_I, ADC_DATA_I are
//          on SYS_CLK
// Notes:   Registers reached only through the serial configuration port
//
// How it works
// - Duplex strap low selects half duplex, high selects full duplex.
// - The low-power register default comes from the duplex and default-select straps.
// - Port select held high keeps the serial port idle; defaults apply.
// - Reset pin low or writing bit 5 of 0x00 reloads strap defaults.
// - Only hardware reset starts calibration and filter tuning.
// - No reset clears the transmit interpolation filter contents.
// - Defaults load when reset falls; calibration starts when it rises.
// - Analog loopback feeds converter output into the transmit path.
// - Digital loopback returns transmit port words on the receive port.
// - Receive port tri-state bit floats receive outputs in any mode.
// - Bias register: gain bias 7:5, sampled bias 4:3, converter 2:0.
// - Bias register reads zero after any reset.
// - Converter low-power bit equals converter bias field value 011.
`timescale 1ns/100ps
`default_nettype none
`include "rmblc_params.svh"
module rmblc_ctrl #(
	parameter int TX_W  = 6,
	parameter int ADC_W = 12
) (
	input  wire logic             SYS_CLK_I,        // 100 MHz clock
	input  wire logic             SYS_RST_I,        // Async reset, high
	input  wire logic             RESET_N_I,        // Reset pin, low
	input  wire logic             MODE_I,           // Duplex strap
	input  wire logic             CONFIG_I,         // Default-select strap
	input  wire logic             PORT_SELECT_N_I,  // Serial select, low
	input  wire logic             SCLK_I,           // Serial clock pin
	input  wire logic             SDIO_I,           // Serial data in
	output logic                  SDIO_O,           // Serial data out
	output logic                  SDIO_OE_O,        // Serial drive enable
	input  wire logic [TX_W-1:0]  TX_DATA_I,        // Transmit port pins
	input  wire logic [ADC_W-1:0] TX_WORD_I,        // Assembled host word
	input  wire logic [ADC_W-1:0] ADC_DATA_I,       // Converter output
	input  wire logic [TX_W-1:0]  RX_WORD_I,        // Normal receive nibble
	output logic      [ADC_W-1:0] TX_PATH_DATA_O,   // To interpolator
	output logic      [TX_W-1:0]  RX_DATA_O,        // Receive port pins
	output logic                  RX_DATA_OE_O,     // Receive drive enable
	output logic                  DUPLEX_FULL_O,    // 1 = full duplex
	output logic                  CAL_START_O,      // Calibration pulse
	output logic                  DEFAULTS_LOAD_O,  // Defaults reloaded
	output logic      [2:0]       CONT_GAIN_BIAS_O, // Gain stage bias
	output logic      [1:0]       SAMP_GAIN_BIAS_O, // Sampled stage bias
	output logic      [2:0]       ADC_BIAS_O        // Converter bias
);
	import rmblc_pkg::*;

	// ------------------------------------------------------------------
	// Pin synchronisers
	// ------------------------------------------------------------------
	logic            rst_n_f;
	logic [1:0]      strap_f;
	logic [2:0]      sp_f;
	logic [TX_W-1:0] tx_pin_f;

	// The pin must stay low for the filter to see it; a host pulse of
	// RESET_MIN_CYC cycles outlasts the agreement window
	rmblc_sync #(.W(1), .INIT(1'b0)) u_sync_rst (
		.clk_i (SYS_CLK_I),
		.rst_i (SYS_RST_I),
		.d_i   (RESET_N_I),
		.q_o   (rst_n_f)
	);

	rmblc_sync #(.W(2), .INIT(2'b00)) u_sync_strap (
		.clk_i (SYS_CLK_I),
		.rst_i (SYS_RST_I),
		.d_i   ({MODE_I, CONFIG_I}),
		.q_o   (strap_f)
	);

	rmblc_sync #(.W(3), .INIT(3'b100)) u_sync_sp (
		.clk_i (SYS_CLK_I),
		.rst_i (SYS_RST_I),
		.d_i   ({PORT_SELECT_N_I, SCLK_I, SDIO_I}),
		.q_o   (sp_f)
	);

	rmblc_sync #(.W(TX_W), .INIT('0)) u_sync_tx (
		.clk_i (SYS_CLK_I),
		.rst_i (SYS_RST_I),
		.d_i   (TX_DATA_I),
		.q_o   (tx_pin_f)
	);

	// ------------------------------------------------------------------
	// Reset sequencing
	// ------------------------------------------------------------------
	logic        rst_n_q;
	logic        hw_rst;
	logic        soft_rst;
	logic        load_defaults;
	logic [1:0]  strap;
	logic        sp_wr;
	rmblc_addr_t sp_addr;
	rmblc_byte_t sp_wdata;

	// Pin held low counts as reset from the first filtered low level;
	// the cycles after the block comes out of system reset count too, until the filter sees the pin high
	assign hw_rst   = ~rst_n_f;
	assign soft_rst = sp_wr && sp_addr == `RMBLC_OFS_SOFT_RESET &&
		sp_wdata[`RMBLC_BIT_SOFT_RESET];
	assign load_defaults = hw_rst | soft_rst;

	always_ff @(posedge SYS_CLK_I or posedge SYS_RST_I) begin
		if (SYS_RST_I) begin
			rst_n_q <= 1'b0;
		end else begin
			rst_n_q <= rst_n_f;
		end
	end

	// Tuning starts on the release, never on a soft reset
	always_ff @(posedge SYS_CLK_I or posedge SYS_RST_I) begin
		if (SYS_RST_I) begin
			CAL_START_O <= 1'b0;
		end else begin
			CAL_START_O <= rst_n_f & ~rst_n_q;
		end
	end

	always_ff @(posedge SYS_CLK_I or posedge SYS_RST_I) begin
		if (SYS_RST_I) begin
			DEFAULTS_LOAD_O <= 1'b0;
		end else begin
			DEFAULTS_LOAD_O <= load_defaults;
		end
	end

	// Straps are caught while a reset is in force, so later strap
	// wiggles do not disturb a running configuration
	always_ff @(posedge SYS_CLK_I or posedge SYS_RST_I) begin
		if (SYS_RST_I) begin
			strap <= 2'b00;
		end else if (load_defaults) begin
			strap <= strap_f;
		end
	end

	always_ff @(posedge SYS_CLK_I or posedge SYS_RST_I) begin
		if (SYS_RST_I) begin
			DUPLEX_FULL_O <= 1'b0;
		end else begin
			DUPLEX_FULL_O <= strap[1];
		end
	end

	// ------------------------------------------------------------------
	// Register file
	// ------------------------------------------------------------------
	rmblc_byte_t adc_low_power_ctrl;
	rmblc_byte_t test_loopback_ctrl;
	rmblc_byte_t rx_bias_adjust;
	rmblc_byte_t def_adc_lp;
	rmblc_byte_t rd_data;

	always_comb begin
		case (strap_f)
		2'b00:   def_adc_lp = `RMBLC_DEF_ADC_LP_00;
		2'b01:   def_adc_lp = `RMBLC_DEF_ADC_LP_01;
		2'b10:   def_adc_lp = `RMBLC_DEF_ADC_LP_10;
		default: def_adc_lp = `RMBLC_DEF_ADC_LP_11;
		endcase
	end

	// Defaults are forced every cycle the pin stays low
	always_ff @(posedge SYS_CLK_I or posedge SYS_RST_I) begin
		if (SYS_RST_I) begin
			adc_low_power_ctrl <= `RMBLC_DEF_ADC_LP_00;
		end else if (load_defaults) begin
			adc_low_power_ctrl <= def_adc_lp;
		end else if (sp_wr && sp_addr == `RMBLC_OFS_ADC_LOW_PWR) begin
			adc_low_power_ctrl <= sp_wdata;
		end
	end

	always_ff @(posedge SYS_CLK_I or posedge SYS_RST_I) begin
		if (SYS_RST_I) begin
			test_loopback_ctrl <= `RMBLC_DEF_TEST_LOOP;
		end else if (load_defaults) begin
			test_loopback_ctrl <= `RMBLC_DEF_TEST_LOOP;
		end else if (sp_wr && sp_addr == `RMBLC_OFS_TEST_LOOP) begin
			test_loopback_ctrl <= sp_wdata;
		end
	end

	always_ff @(posedge SYS_CLK_I or posedge SYS_RST_I) begin
		if (SYS_RST_I) begin
			rx_bias_adjust <= `RMBLC_DEF_RX_BIAS;
		end else if (load_defaults) begin
			rx_bias_adjust <= `RMBLC_DEF_RX_BIAS;
		end else if (sp_wr && sp_addr == `RMBLC_OFS_RX_BIAS) begin
			rx_bias_adjust <= sp_wdata;
		end
	end

	// Soft reset bit self-clears; its read shows the latched straps
	always_comb begin
		if (sp_addr == `RMBLC_OFS_SOFT_RESET) begin
			rd_data = {6'h00, strap};
		end else if (sp_addr == `RMBLC_OFS_ADC_LOW_PWR) begin
			rd_data = adc_low_power_ctrl;
		end else if (sp_addr == `RMBLC_OFS_TEST_LOOP) begin
			rd_data = test_loopback_ctrl;
		end else if (sp_addr == `RMBLC_OFS_RX_BIAS) begin
			rd_data = rx_bias_adjust;
		end else begin
			rd_data = 8'h00;
		end
	end

	// With select parked high the slave never leaves idle
	rmblc_serial u_serial (
		.clk_i    (SYS_CLK_I),
		.rst_i    (SYS_RST_I),
		.sel_n_i  (sp_f[2] | hw_rst),
		.sclk_i   (sp_f[1]),
		.sdi_i    (sp_f[0]),
		.rdata_i  (rd_data),
		.addr_o   (sp_addr),
		.wdata_o  (sp_wdata),
		.wr_o     (sp_wr),
		.sdo_o    (SDIO_O),
		.sdo_oe_o (SDIO_OE_O)
	);

	// ------------------------------------------------------------------
	// Bias outputs
	// ------------------------------------------------------------------
	always_ff @(posedge SYS_CLK_I or posedge SYS_RST_I) begin
		if (SYS_RST_I) begin
			CONT_GAIN_BIAS_O <= 3'h0;
			SAMP_GAIN_BIAS_O <= 2'h0;
			ADC_BIAS_O       <= 3'h0;
		end else begin
			CONT_GAIN_BIAS_O <= rx_bias_adjust[7:5];
			SAMP_GAIN_BIAS_O <= rx_bias_adjust[4:3];
			if (adc_low_power_ctrl[`RMBLC_BIT_ADC_LOW_PWR]) begin
				ADC_BIAS_O <= `RMBLC_ADC_LP_BIAS;
			end else begin
				ADC_BIAS_O <= rx_bias_adjust[2:0];
			end
		end
	end

	// ------------------------------------------------------------------
	// Data routing
	// ------------------------------------------------------------------
	// The transmit path register is only cleared by system reset; pin and
	// soft resets leave filter feed data alone, so a flush must be done
	// by streaming zeros
	always_ff @(posedge SYS_CLK_I or posedge SYS_RST_I) begin
		if (SYS_RST_I) begin
			TX_PATH_DATA_O <= '0;
		end else if (test_loopback_ctrl[`RMBLC_BIT_ANA_LOOP]) begin
			TX_PATH_DATA_O <= ADC_DATA_I;
		end else begin
			TX_PATH_DATA_O <= TX_WORD_I;
		end
	end

	always_ff @(posedge SYS_CLK_I or posedge SYS_RST_I) begin
		if (SYS_RST_I) begin
			RX_DATA_O <= '0;
		end else if (test_loopback_ctrl[`RMBLC_BIT_DIG_LOOP]) begin
			RX_DATA_O <= tx_pin_f;
		end else begin
			RX_DATA_O <= RX_WORD_I;
		end
	end

	// Float regardless of duplex mode
	always_ff @(posedge SYS_CLK_I or posedge SYS_RST_I) begin
		if (SYS_RST_I) begin
			RX_DATA_OE_O <= 1'b0;
		end else begin
			RX_DATA_OE_O <= ~test_loopback_ctrl[`RMBLC_BIT_RX_TRISTATE];
		end
	end
endmodule : rmblc_ctrl
`default_nettype wire

// >>> rmblc_ctrl_assertions.sv
// Purpose: Port checks of the reset, bias and loopback block
// Assumes: One clock domain; straps held steady during pin reset
// Notes:   Bind statement follows the module
`timescale 1ns/100ps
`default_nettype none
module rmblc_ctrl_checker #(
	parameter int TX_W  = 6,
	parameter int ADC_W = 12
) (
	input wire logic             SYS_CLK_I,        // Clock
	input wire logic             SYS_RST_I,        // Reset
	input wire logic             RESET_N_I,        // Reset pin
	input wire logic             MODE_I,           // Duplex strap
	input wire logic             PORT_SELECT_N_I,  // Port select
	input wire logic [TX_W-1:0]  TX_DATA_I,        // Tx pins
	input wire logic [ADC_W-1:0] TX_WORD_I,        // Host word
	input wire logic [ADC_W-1:0] ADC_DATA_I,       // Converter
	input wire logic [TX_W-1:0]  RX_WORD_I,        // Rx nibble
	input wire logic [ADC_W-1:0] TX_PATH_DATA_O,   // Tx path
	input wire logic [TX_W-1:0]  RX_DATA_O,        // Rx pins
	input wire logic             RX_DATA_OE_O,     // Rx enable
	input wire logic             DUPLEX_FULL_O,    // Duplex
	input wire logic             CAL_START_O,      // Calibration
	input wire logic [2:0]       CONT_GAIN_BIAS_O, // Gain bias
	input wire logic [1:0]       SAMP_GAIN_BIAS_O, // Sampled bias
	input wire logic [2:0]       ADC_BIAS_O,       // Converter bias
	input wire logic             SDIO_OE_O         // Serial enable
);
	default clocking cb @(posedge SYS_CLK_I);
	endclocking
	default disable iff (SYS_RST_I);
	// --------------------
	// Reset behaviour
	// --------------------
	a_duplex_strap: assert property (
		($stable(MODE_I) && !RESET_N_I)[*8] |-> DUPLEX_FULL_O == MODE_I)
		else $error("duplex mode not taken from strap");
	a_cal_after_rise: assert property (
		$rose(RESET_N_I) |-> ##[3:8] CAL_START_O)
		else $error("no calibration start after reset pin rise");
	a_cal_single: assert property (
		CAL_START_O |=> !CAL_START_O)
		else $error("calibration start longer than one cycle");
	a_reset_bias_zero: assert property (
		(!RESET_N_I)[*8] |-> {CONT_GAIN_BIAS_O, SAMP_GAIN_BIAS_O,
		ADC_BIAS_O} == 8'h00)
		else $error("bias outputs not nominal in reset");
	a_reset_loop_clear: assert property (
		(!RESET_N_I)[*8] |-> RX_DATA_OE_O && RX_DATA_O == $past(RX_WORD_I)
		&& TX_PATH_DATA_O == $past(TX_WORD_I))
		else $error("loopback or tristate active in reset");
	// --------------------
	// Data routing and port
	// --------------------
	a_tx_path_source: assert property (
		!$past(SYS_RST_I) |-> TX_PATH_DATA_O == $past(TX_WORD_I)
		|| TX_PATH_DATA_O == $past(ADC_DATA_I))
		else $error("tx path carries neither source");
	a_rx_port_source: assert property (
		!$past(SYS_RST_I) |-> RX_DATA_O == $past(RX_WORD_I)
		|| RX_DATA_O == $past(TX_DATA_I, 4)
		|| RX_DATA_O == $past(TX_DATA_I, 5)
		|| RX_DATA_O == $past(TX_DATA_I, 6))
		else $error("rx port carries neither source");
	a_port_idle: assert property (
		(PORT_SELECT_N_I && RESET_N_I)[*8] |-> $stable(CONT_GAIN_BIAS_O)
		&& $stable(ADC_BIAS_O) && $stable(RX_DATA_OE_O))
		else $error("settings moved with port deselected");
	a_sdio_quiet: assert property (
		PORT_SELECT_N_I[*8] |-> !SDIO_OE_O)
		else $error("serial data driven while deselected");
	c_cal: cover property (CAL_START_O);
	c_tristate: cover property (!RX_DATA_OE_O);
	c_read: cover property (SDIO_OE_O);
endmodule : rmblc_ctrl_checker
bind rmblc_ctrl rmblc_ctrl_checker #(.TX_W(TX_W), .ADC_W(ADC_W)) chk_u (
	.SYS_CLK_I, .SYS_RST_I, .RESET_N_I, .MODE_I, .PORT_SELECT_N_I,
	.TX_DATA_I, .TX_WORD_I, .ADC_DATA_I, .RX_WORD_I, .TX_PATH_DATA_O,
	.RX_DATA_O, .RX_DATA_OE_O, .DUPLEX_FULL_O, .CAL_START_O,
	.CONT_GAIN_BIAS_O, .SAMP_GAIN_BIAS_O, .ADC_BIAS_O, .SDIO_OE_O);
`default_nettype wire

// >>> rmblc_host_model.sv
// Purpose: Host controller driving reset pin and serial port
// Assumes: Changes its pins on falling clock edges only
// Notes:   Tasks are called from the testbench
`timescale 1ns/100ps
`default_nettype none
module rmblc_host_model (
	input  wire logic clk_i,   // System clock
	input  wire logic sdio_i,  // Resolved data wire
	output logic      rst_n_o, // Reset pin
	output logic      sel_n_o, // Port select
	output logic      sclk_o,  // Serial clock
	output logic      sdo_o,   // Host data
	output logic      oe_o     // Host drives data
);
	initial begin
		rst_n_o = 1'b0; // Held low from power-up
		sel_n_o = 1'b1;
		sclk_o = 1'b0;
		sdo_o = 1'b0;
		oe_o = 1'b0;
	end
	task automatic wait_n(input int n);
		repeat (n) @(negedge clk_i);
	endtask : wait_n
	task automatic pin_reset(input logic lvl, input int n);
		rst_n_o = lvl;
		repeat ((!lvl && n < 5) ? 5 : n) @(negedge clk_i);
	endtask : pin_reset
	// Slow half periods exercise the filter margin, fast ones its limit
	task automatic xfer(input logic sel, input int hp,
		input logic [15:0] frame, output logic [7:0] rd);
		sel_n_o = ~sel;
		oe_o = 1'b1;
		wait_n(8);
		for (int i = 15; i >= 0; i--) begin
			if (i < 8 && frame[15])
				oe_o = 1'b0;
			sdo_o = frame[i];
			sclk_o = 1'b0;
			wait_n(hp);
			sclk_o = 1'b1;
			if (i < 8)
				rd[i] = sdio_i;
			wait_n(hp);
		end
		sel_n_o = 1'b1;
		oe_o = 1'b0;
		wait_n(10);
	endtask : xfer
endmodule : rmblc_host_model
`default_nettype wire

// >>> reset_mode_bias_loopback_ctrl_test.sv
// Purpose: Self-checking bench of the reset, bias and loopback block
// Assumes: Host model speaks the serial port; straps from the bench
// Notes:   Host word, converter and receive word inputs move every cycle so routing is visible
`timescale 1ns/100ps
`default_nettype none
`include "rmblc_params.svh"
module reset_mode_bias_loopback_ctrl_test;
	import rmblc_pkg::*;
	// Starts low without a time-zero edge, so no stimulus races its init
	logic        clk = 1'b0;
	logic        rst, mode, cfg, sdio_w, h_rst_n, h_sel_n, h_sclk;
	logic        h_d, h_oe, sdo, sdo_oe, rx_oe, dup, cal, dload;
	logic [5:0]  tx_data, rx_word, rx_data;
	logic [11:0] tx_word, adc, tx_path;
	logic [2:0]  cgb, adcb;
	logic [1:0]  sgb;
	rmblc_byte_t rd;
	int          error_cnt, tests_run, cal_cnt, n;
	// Undriven wire shows the inverse so a stale bit cannot pass
	assign sdio_w = sdo_oe ? sdo : (h_oe ? h_d : ~h_d);
	rmblc_host_model host_u (.clk_i(clk), .sdio_i(sdio_w),
		.rst_n_o(h_rst_n), .sel_n_o(h_sel_n), .sclk_o(h_sclk),
		.sdo_o(h_d), .oe_o(h_oe));
	rmblc_ctrl dut_u (.SYS_CLK_I(clk), .SYS_RST_I(rst),
		.RESET_N_I(h_rst_n), .MODE_I(mode), .CONFIG_I(cfg),
		.PORT_SELECT_N_I(h_sel_n), .SCLK_I(h_sclk), .SDIO_I(sdio_w),
		.SDIO_O(sdo), .SDIO_OE_O(sdo_oe), .TX_DATA_I(tx_data),
		.TX_WORD_I(tx_word), .ADC_DATA_I(adc), .RX_WORD_I(rx_word),
		.TX_PATH_DATA_O(tx_path), .RX_DATA_O(rx_data),
		.RX_DATA_OE_O(rx_oe), .DUPLEX_FULL_O(dup), .CAL_START_O(cal),
		.DEFAULTS_LOAD_O(dload), .CONT_GAIN_BIAS_O(cgb),
		.SAMP_GAIN_BIAS_O(sgb), .ADC_BIAS_O(adcb));
	initial begin
		forever #5 clk = ~clk;
	end
	initial begin
		{rst, mode, cfg, error_cnt, tests_run, cal_cnt} = '0;
		rst = 1'b1;
		{tx_data, rx_word, tx_word, adc} = {6'h2a, 6'h00, 12'h100, 12'h800};
	end
	always @(negedge clk) begin
		tx_word <= tx_word + 12'h001;
		adc     <= adc - 12'h003;
		rx_word <= rx_word + 6'h01;
	end
	// Counted on the falling edge, mid-cycle, so a one-cycle pulse counts once
	always @(negedge clk)
		if (cal === 1'b1)
			cal_cnt++;
	// --------------------
	// Helpers
	// --------------------
	task automatic check(input string what, input logic [11:0] seen, exp);
		tests_run++;
		if (seen !== exp) begin
			error_cnt++;
			$display("MISMATCH %s expected %h seen %h", what, exp, seen);
		end
	endtask : check
	task automatic wr(input logic [6:0] a, input logic [7:0] d);
		host_u.xfer(1'b1, 7, {1'b0, a, d}, rd);
	endtask : wr
	task automatic rdc(input string what, input logic [6:0] a,
		input logic [7:0] exp);
		host_u.xfer(1'b1, 12, {1'b1, a, 8'h00}, rd);
		check(what, 12'(rd), 12'(exp));
	endtask : rdc
	task automatic test_done();
		$display("Checks %0d mismatches %0d", tests_run, error_cnt);
		if (error_cnt == 0 && tests_run > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask : test_done
	initial begin
		#500us;
		error_cnt++;
		test_done();
	end
	// --------------------
	// Sequence
	// --------------------
	initial begin
		repeat (16) @(negedge clk);
		rst = 1'b0;
		for (int s = 0; s < 4; s++) begin
			{mode, cfg} = 2'(s);
			host_u.pin_reset(1'b0, s == 0 ? 100 : 12);
			check("bias in reset", {4'h0, cgb, sgb, adcb}, 12'h0);
			check("defaults flag", 12'(dload), 12'h1);
			check("early cal", 12'(cal_cnt), 12'(s));
			host_u.pin_reset(1'b1, 12);
			check("cal pulse", 12'(cal_cnt), 12'(s + 1));
			check("duplex", 12'(dup), 12'(mode));
			rdc("strap reg", `RMBLC_OFS_SOFT_RESET, {6'h0, mode, cfg});
			rdc("lp reset", `RMBLC_OFS_ADC_LOW_PWR, 8'h00);
			rdc("bias reset", `RMBLC_OFS_RX_BIAS, 8'h00);
			rdc("test reset", `RMBLC_OFS_TEST_LOOP, 8'h00);
			wr(`RMBLC_OFS_RX_BIAS, 8'hff);
			wr(`RMBLC_OFS_TEST_LOOP, 8'h20);
			check("rx tristate", 12'(rx_oe), 12'h0);
		end
		check("bias fields", {4'h0, cgb, sgb, adcb}, 12'hff);
		wr(`RMBLC_OFS_RX_BIAS, 8'ha5);
		check("bias fields", {4'h0, cgb, sgb, adcb}, 12'ha5);
		wr(`RMBLC_OFS_ADC_LOW_PWR, 8'h10);
		check("low power", {4'h0, cgb, sgb, adcb}, 12'ha3);
		rdc("bias kept", `RMBLC_OFS_RX_BIAS, 8'ha5);
		wr(`RMBLC_OFS_TEST_LOOP, 8'h80);
		check("analog loop", tx_path, adc);
		check("rx driven", 12'(rx_oe), 12'h1);
		wr(`RMBLC_OFS_TEST_LOOP, 8'h40);
		check("tx normal", tx_path, tx_word);
		for (int v = 0; v < 2; v++) begin
			tx_data = v ? 6'h2a : 6'h15;
			host_u.wait_n(10);
			check("digital loop", 12'(rx_data), 12'(tx_data));
		end
		host_u.xfer(1'b0, 7, {1'b0, `RMBLC_OFS_RX_BIAS, 8'h3c}, rd);
		rdc("port idle", `RMBLC_OFS_RX_BIAS, 8'ha5);
		n = cal_cnt;
		cfg = 1'b0;
		wr(`RMBLC_OFS_SOFT_RESET, 8'h20);
		rdc("soft bias", `RMBLC_OFS_RX_BIAS, 8'h00);
		rdc("soft straps", `RMBLC_OFS_SOFT_RESET, 8'h02);
		rdc("soft loop", `RMBLC_OFS_TEST_LOOP, 8'h00);
		check("soft no cal", 12'(cal_cnt), 12'(n));
		check("tx kept", tx_path, tx_word);
		check("rx normal", 12'(rx_data), 12'(rx_word));
		test_done();
	end
endmodule : reset_mode_bias_loopback_ctrl_test
`default_nettype wire
